//--- hdl/tcs_pkg.sv
package tcs_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] TCS_ADDR_SYNTH   = 8'h06;
    localparam logic [7:0] TCS_ADDR_OSC     = 8'h07;
    localparam logic [7:0] TCS_ADDR_FILTER  = 8'h08;
    localparam logic [7:0] TCS_ADDR_CONTROL = 8'h09;
    localparam logic [7:0] TCS_ADDR_POWER   = 8'h0A;
    localparam logic [7:0] TCS_ADDR_TEST    = 8'h0B;
    localparam logic [7:0] TCS_ADDR_STATUS1 = 8'h0C;

    localparam int TCS_NUM_CFG = 6;
    localparam logic [7:0] TCS_PTR_STEP = 8'h01;
    localparam logic [7:0] TCS_BYTE_ZERO = 8'h00;

    // ----------------------------------------------------------------
    // reset values and writable masks, index 0 is the synth register
    // ----------------------------------------------------------------
    localparam logic [TCS_NUM_CFG*8-1:0] TCS_CFG_RESET = {
        8'h08, 8'h00, 8'h00, 8'h4B, 8'hCC, 8'hC0
    };
    localparam logic [TCS_NUM_CFG*8-1:0] TCS_CFG_MASK = {
        8'hEF, 8'h7F, 8'hAF, 8'hFF, 8'hFF, 8'hE0
    };

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int TCS_DIV_SEL_BIT    = 7;
    localparam int TCS_PUMP_SRC_BIT   = 6;
    localparam int TCS_PUMP_LVL_BIT   = 5;
    localparam int TCS_BAND_MSB       = 7;
    localparam int TCS_BAND_LSB       = 3;
    localparam int TCS_AUTO_EN_BIT    = 2;
    localparam int TCS_ADC_LATCH_BIT  = 1;
    localparam int TCS_ADC_READ_BIT   = 0;
    localparam int TCS_STANDBY_BIT    = 7;
    localparam int TCS_FACT_PD_BIT    = 5;
    localparam int TCS_GAIN_MSB       = 3;
    localparam int TCS_GAIN_LSB       = 0;
    localparam int TCS_OFF_MSB        = 6;
    localparam int TCS_OFF_LSB        = 0;
    localparam int TCS_PTEST_MSB      = 7;
    localparam int TCS_PTEST_LSB      = 5;
    localparam int TCS_FAST_LOCK_BIT  = 3;
    localparam int TCS_REFMUX_MSB     = 2;
    localparam int TCS_REFMUX_LSB     = 0;
    localparam int TCS_POR_BIT        = 7;
    localparam int TCS_SUCCESS_BIT    = 6;
    localparam int TCS_IDLE_BIT       = 5;
    localparam int TCS_LOCK_BIT       = 4;

    // ----------------------------------------------------------------
    // transfer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TCS_IDLE,
        TCS_WR_ADDR,
        TCS_WR_DATA,
        TCS_RD_DATA
    } tcs_state_type;

endpackage

//--- hdl/tcs_cfg_reg.sv
`timescale 1ns/1ps
module tcs_cfg_reg
    import tcs_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    output logic      [7:0] o_value
);

    // ----------------------------------------------------------------
    // one configuration byte, masked bits stay zero
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_value <= RESET_VALUE;
        end else if (i_wr_en) begin
            o_value <= i_wr_data & WRITE_MASK;
        end
    end

endmodule

//--- hdl/tcs_status_byte.sv
`timescale 1ns/1ps
module tcs_status_byte
    import tcs_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_status_read,
    input  wire logic       i_xfer_stop,
    input  wire logic       i_auto_enable,
    input  wire logic       i_auto_select_success,
    input  wire logic       i_auto_select_idle,
    input  wire logic       i_lock_indicator,
    output logic            o_por,
    output logic      [7:0] o_status_byte
);

    logic status_seen;

    // ----------------------------------------------------------------
    // status read seen in the current transfer
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            status_seen <= 1'b0;
        end else if (i_xfer_stop) begin
            status_seen <= 1'b0;
        end else if (i_status_read) begin
            status_seen <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // power-cycle flag
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_por <= 1'b1;
        end else if (i_xfer_stop && (status_seen || i_status_read)) begin
            o_por <= 1'b0;
        end
    end

    always_comb begin
        o_status_byte                  = TCS_BYTE_ZERO;
        o_status_byte[TCS_POR_BIT]     = o_por;
        o_status_byte[TCS_SUCCESS_BIT] = i_auto_select_success & i_auto_enable;
        o_status_byte[TCS_IDLE_BIT]    = i_auto_select_idle;
        o_status_byte[TCS_LOCK_BIT]    = i_lock_indicator;
    end

endmodule

//--- hdl/tcs_regs.sv
`timescale 1ns/1ps
module tcs_regs
    import tcs_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_xfer_start,
    input  wire logic       i_xfer_read,
    input  wire logic       i_xfer_stop,
    input  wire logic       i_wr_byte_valid,
    input  wire logic [7:0] i_wr_byte,
    output logic            o_wr_ack,
    input  wire logic       i_rd_req,
    output logic      [7:0] o_rd_data,
    output logic            o_rd_valid,
    input  wire logic       i_auto_select_success,
    input  wire logic       i_auto_select_idle,
    input  wire logic       i_lock_indicator,
    input  wire logic       i_auto_pump_current_high,
    output logic            o_output_divider_select,
    output logic            o_pump_current_source_select,
    output logic            o_pump_current_level,
    output logic            o_pump_current_high,
    output logic      [4:0] o_oscillator_band_select,
    output logic            o_auto_band_select_enable,
    output logic            o_tune_adc_latch,
    output logic            o_tune_adc_read_enable,
    output logic      [7:0] o_filter_corner_code,
    output logic            o_soft_standby,
    output logic            o_factory_power_down,
    output logic      [3:0] o_baseband_gain_code,
    output logic            o_synth_loop_off,
    output logic            o_divider_off,
    output logic            o_osc_core_off,
    output logic            o_baseband_off,
    output logic            o_downmixer_off,
    output logic            o_input_gain_stage_off,
    output logic            o_front_end_off,
    output logic      [2:0] o_pump_test_mode,
    output logic            o_fast_lock_enable,
    output logic      [2:0] o_ref_output_mux,
    output logic            o_power_cycle_flag
);

    tcs_state_type state;
    logic    [7:0] reg_ptr;
    logic    [7:0] cfg [TCS_NUM_CFG];
    logic    [7:0] status_byte;
    logic    [7:0] next_rd_data;
    logic          data_write;
    logic          data_read;
    logic          status_read;
    logic    [6:0] off_bits;

    // ----------------------------------------------------------------
    // transfer sequencing
    // ----------------------------------------------------------------
    assign data_write  = i_wr_byte_valid && (state == TCS_WR_DATA) && !i_xfer_stop;
    assign data_read   = i_rd_req && (state == TCS_RD_DATA) && !i_xfer_stop;
    assign status_read = data_read && (reg_ptr == TCS_ADDR_STATUS1);
    assign o_wr_ack    = i_wr_byte_valid && ((state == TCS_WR_ADDR) || (state == TCS_WR_DATA));

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= TCS_IDLE;
        end else if (i_xfer_stop) begin
            state <= TCS_IDLE;
        end else if (i_xfer_start) begin
            state <= i_xfer_read ? TCS_RD_DATA : TCS_WR_ADDR;
        end else if (i_wr_byte_valid && state == TCS_WR_ADDR) begin
            state <= TCS_WR_DATA;
        end
    end

    // ----------------------------------------------------------------
    // register pointer
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            reg_ptr <= TCS_BYTE_ZERO;
        end else if (!i_xfer_stop && !i_xfer_start && i_wr_byte_valid
                     && state == TCS_WR_ADDR) begin
            reg_ptr <= i_wr_byte;
        end else if (data_write || data_read) begin
            reg_ptr <= reg_ptr + TCS_PTR_STEP;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < TCS_NUM_CFG; g++) begin : g_cfg
            tcs_cfg_reg #(
                .RESET_VALUE (TCS_CFG_RESET[g*8 +: 8]),
                .WRITE_MASK  (TCS_CFG_MASK[g*8 +: 8])
            ) u_cfg (
                .i_clk     (i_clk),
                .i_resetn  (i_resetn),
                .i_wr_en   (data_write && (reg_ptr == TCS_ADDR_SYNTH + 8'(g))),
                .i_wr_data (i_wr_byte),
                .o_value   (cfg[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // status byte and power-cycle flag
    // ----------------------------------------------------------------
    tcs_status_byte u_status (
        .i_clk                 (i_clk),
        .i_resetn              (i_resetn),
        .i_status_read         (status_read),
        .i_xfer_stop           (i_xfer_stop),
        .i_auto_enable         (cfg[1][TCS_AUTO_EN_BIT]),
        .i_auto_select_success (i_auto_select_success),
        .i_auto_select_idle    (i_auto_select_idle),
        .i_lock_indicator      (i_lock_indicator),
        .o_por                 (o_power_cycle_flag),
        .o_status_byte         (status_byte)
    );

    // ----------------------------------------------------------------
    // read path, write-only and foreign addresses read zero
    // ----------------------------------------------------------------
    always_comb begin
        next_rd_data = TCS_BYTE_ZERO;
        if (reg_ptr == TCS_ADDR_STATUS1) begin
            next_rd_data = status_byte;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rd_data  <= TCS_BYTE_ZERO;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= data_read;
            if (data_read) begin
                o_rd_data <= next_rd_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // block controls
    // ----------------------------------------------------------------
    assign off_bits = cfg[4][TCS_OFF_MSB:TCS_OFF_LSB];

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_output_divider_select      <= TCS_CFG_RESET[TCS_DIV_SEL_BIT];
            o_pump_current_source_select <= TCS_CFG_RESET[TCS_PUMP_SRC_BIT];
            o_pump_current_level         <= TCS_CFG_RESET[TCS_PUMP_LVL_BIT];
            o_pump_current_high          <= TCS_CFG_RESET[TCS_PUMP_LVL_BIT];
        end else begin
            o_output_divider_select      <= cfg[0][TCS_DIV_SEL_BIT];
            o_pump_current_source_select <= cfg[0][TCS_PUMP_SRC_BIT];
            o_pump_current_level         <= cfg[0][TCS_PUMP_LVL_BIT];
            o_pump_current_high          <= cfg[0][TCS_PUMP_SRC_BIT]
                                            ? i_auto_pump_current_high
                                            : cfg[0][TCS_PUMP_LVL_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_oscillator_band_select  <= TCS_CFG_RESET[8+TCS_BAND_MSB:8+TCS_BAND_LSB];
            o_auto_band_select_enable <= TCS_CFG_RESET[8+TCS_AUTO_EN_BIT];
            o_tune_adc_latch          <= 1'b0;
            o_tune_adc_read_enable    <= 1'b0;
        end else begin
            o_oscillator_band_select  <= cfg[1][TCS_BAND_MSB:TCS_BAND_LSB];
            o_auto_band_select_enable <= cfg[1][TCS_AUTO_EN_BIT];
            o_tune_adc_latch          <= cfg[1][TCS_ADC_LATCH_BIT]
                                         && !cfg[1][TCS_AUTO_EN_BIT];
            o_tune_adc_read_enable    <= cfg[1][TCS_ADC_READ_BIT]
                                         && !cfg[1][TCS_AUTO_EN_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_filter_corner_code <= TCS_CFG_RESET[23:16];
            o_soft_standby       <= 1'b0;
            o_factory_power_down <= 1'b0;
            o_baseband_gain_code <= TCS_CFG_RESET[24+TCS_GAIN_MSB:24+TCS_GAIN_LSB];
        end else begin
            o_filter_corner_code <= cfg[2];
            o_soft_standby       <= cfg[3][TCS_STANDBY_BIT];
            o_factory_power_down <= cfg[3][TCS_FACT_PD_BIT];
            o_baseband_gain_code <= cfg[3][TCS_GAIN_MSB:TCS_GAIN_LSB];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            {o_synth_loop_off, o_divider_off, o_osc_core_off, o_baseband_off,
             o_downmixer_off, o_input_gain_stage_off, o_front_end_off} <= 7'h00;
        end else begin
            {o_synth_loop_off, o_divider_off, o_osc_core_off, o_baseband_off,
             o_downmixer_off, o_input_gain_stage_off, o_front_end_off}
                <= off_bits | {7{cfg[3][TCS_STANDBY_BIT]}};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pump_test_mode   <= TCS_CFG_RESET[40+TCS_PTEST_MSB:40+TCS_PTEST_LSB];
            o_fast_lock_enable <= TCS_CFG_RESET[40+TCS_FAST_LOCK_BIT];
            o_ref_output_mux   <= TCS_CFG_RESET[40+TCS_REFMUX_MSB:40+TCS_REFMUX_LSB];
        end else begin
            o_pump_test_mode   <= cfg[5][TCS_PTEST_MSB:TCS_PTEST_LSB];
            o_fast_lock_enable <= cfg[5][TCS_FAST_LOCK_BIT];
            o_ref_output_mux   <= cfg[5][TCS_REFMUX_MSB:TCS_REFMUX_LSB];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_wr_osc;
        data_write && reg_ptr == TCS_ADDR_OSC;
    endsequence

    sequence s_wr_filter;
        data_write && reg_ptr == TCS_ADDR_FILTER;
    endsequence

    sequence s_rd_status;
        status_read;
    endsequence

    chk_div_default: assert property (@(posedge i_clk)
        $rose(i_resetn) |-> o_output_divider_select && o_pump_current_source_select)
        else $error("divider or pump source default wrong");

    chk_pump_source: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $past(i_resetn) |-> o_pump_current_high == (o_pump_current_source_select
            ? $past(i_auto_pump_current_high) : o_pump_current_level))
        else $error("pump current source mismatch");

    chk_band_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_wr_osc ##1 !i_resetn == 1'b0 |=> o_oscillator_band_select
            == $past(i_wr_byte[TCS_BAND_MSB:TCS_BAND_LSB], 2))
        else $error("band field not taken from write");

    chk_auto_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_wr_osc |-> ##2 o_auto_band_select_enable == $past(i_wr_byte[TCS_AUTO_EN_BIT], 2))
        else $error("autoselect enable not written");

    chk_adc_gating: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_tune_adc_latch || o_tune_adc_read_enable) |-> !o_auto_band_select_enable)
        else $error("adc control active with autoselect");

    chk_filter_code: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_wr_filter |-> ##2 o_filter_corner_code == $past(i_wr_byte, 2))
        else $error("filter code not written");

    chk_standby_off: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_soft_standby |-> o_synth_loop_off && o_osc_core_off && o_baseband_off
            && o_downmixer_off && o_input_gain_stage_off && o_front_end_off && o_divider_off)
        else $error("standby left a block on");

    chk_shutdown_map: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $past(i_resetn) && !o_soft_standby
            |-> {o_synth_loop_off, o_divider_off, o_osc_core_off, o_baseband_off,
                 o_downmixer_off, o_input_gain_stage_off, o_front_end_off}
            == $past(off_bits))
        else $error("block off bits mismatch");

    chk_gain_zero: assert property (@(posedge i_clk)
        $rose(i_resetn) |-> o_baseband_gain_code == 4'h0 && o_filter_corner_code == 8'h4B)
        else $error("gain or filter default wrong");

    chk_por_set: assert property (@(posedge i_clk)
        $rose(i_resetn) |-> o_power_cycle_flag)
        else $error("power cycle flag not set after reset");

    chk_por_clear: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_rd_status ##[1:8] i_xfer_stop |=> !o_power_cycle_flag ##1 !o_power_cycle_flag)
        else $error("power cycle flag not cleared");

    chk_status_bits: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_rd_status |=> o_rd_valid && o_rd_data[TCS_SUCCESS_BIT]
            == $past(i_auto_select_success && cfg[1][TCS_AUTO_EN_BIT])
            && o_rd_data[TCS_IDLE_BIT] == $past(i_auto_select_idle)
            && o_rd_data[TCS_LOCK_BIT] == $past(i_lock_indicator)
            && o_rd_data[3:0] == 4'h0)
        else $error("status byte content wrong");

    chk_ptr_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (data_write || data_read) |=> reg_ptr == $past(reg_ptr) + TCS_PTR_STEP)
        else $error("register pointer did not advance");

endmodule

//--- sim/tcs_host_model.sv
`timescale 1ns/1ps
module tcs_host_model (
    input  wire logic       i_clk,
    output logic            o_start,
    output logic            o_read,
    output logic            o_stop,
    output logic            o_valid,
    output logic      [7:0] o_byte,
    output logic            o_rd_req
);
    initial begin
        {o_start, o_read, o_stop, o_valid, o_rd_req} = 5'h00;
        o_byte = 8'hA5;
    end
    // ------------------------------------------------------------
    // serial engine events, changed at the falling edge
    // ------------------------------------------------------------
    task automatic pulse(input int k, input logic rd);
        @(negedge i_clk);
        o_read = rd;
        if (k == 0) o_start = 1'b1;
        else o_stop = 1'b1;
        @(negedge i_clk);
        {o_start, o_stop} = 2'h0;
    endtask
    task automatic put(input logic [7:0] b);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_byte = b;
    endtask
    task automatic idle();
        @(negedge i_clk);
        o_valid = 1'b0;
        o_byte = ~o_byte;
    endtask
    task automatic req();
        @(negedge i_clk);
        o_rd_req = 1'b1;
        @(negedge i_clk);
        o_rd_req = 1'b0;
    endtask
endmodule

//--- sim/tcs_regs_tb.sv
`timescale 1ns/1ps
module tcs_regs_tb;
    import tcs_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        succ = 1'b0, idle = 1'b1, lock = 1'b0, aph = 1'b0;
    logic        st, rdm, sp, vld, rq, ack, rv;
    logic [7:0]  wb, rdat, ptr, m [6];
    logic [40:0] ctl;
    logic        por;
    logic [31:0] seed = 32'h0000AF43;
    int          failures = 0, compares = 0;
    always #12.5 i_clk = ~i_clk;
    tcs_host_model i_host (.i_clk(i_clk), .o_start(st), .o_read(rdm), .o_stop(sp),
        .o_valid(vld), .o_byte(wb), .o_rd_req(rq));
    tcs_regs i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_xfer_start(st), .i_xfer_read(rdm),
        .i_xfer_stop(sp), .i_wr_byte_valid(vld), .i_wr_byte(wb), .o_wr_ack(ack),
        .i_rd_req(rq), .o_rd_data(rdat), .o_rd_valid(rv), .i_auto_select_success(succ),
        .i_auto_select_idle(idle), .i_lock_indicator(lock), .i_auto_pump_current_high(aph),
        .o_output_divider_select(ctl[40]), .o_pump_current_source_select(ctl[39]),
        .o_pump_current_level(ctl[38]), .o_pump_current_high(ctl[37]),
        .o_oscillator_band_select(ctl[36:32]), .o_auto_band_select_enable(ctl[31]),
        .o_tune_adc_latch(ctl[30]), .o_tune_adc_read_enable(ctl[29]),
        .o_filter_corner_code(ctl[28:21]), .o_soft_standby(ctl[20]),
        .o_factory_power_down(ctl[19]), .o_baseband_gain_code(ctl[18:15]),
        .o_synth_loop_off(ctl[14]), .o_divider_off(ctl[13]), .o_osc_core_off(ctl[12]),
        .o_baseband_off(ctl[11]), .o_downmixer_off(ctl[10]), .o_input_gain_stage_off(ctl[9]),
        .o_front_end_off(ctl[8]), .o_pump_test_mode(ctl[7:5]), .o_fast_lock_enable(ctl[4]),
        .o_ref_output_mux(ctl[3:1]), .o_power_cycle_flag(ctl[0]));
    // ------------------------------------------------------------
    // model and checks
    // ------------------------------------------------------------
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [40:0] exp_ctl();
        logic [7:0] s, o, c;
        s = m[0];
        o = m[1];
        c = m[3];
        return {s[7:5], s[6] ? aph : s[5], o[7:2], o[1:0] & {2{~o[2]}}, m[2], c[7], c[5],
                c[3:0], m[4][6:0] | {7{c[7]}}, m[5][7:5], m[5][3:0], por};
    endfunction
    task automatic cmp_ctl(input string n, input logic [40:0] e, input logic [40:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic cmp_rd(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        @(negedge i_clk);
        i_resetn = 1'b0;
        repeat (20) @(negedge i_clk);
        i_resetn = 1'b1;
        m = '{8'hC0, 8'hCC, 8'h4B, 8'h00, 8'h00, 8'h08};
        por = 1'b1;
    endtask
    task automatic settle();
        logic [7:0] r;
        @(negedge i_clk);
        r = xs();
        {succ, idle, lock, aph} = r[3:0];
        repeat (3) @(negedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input int n, input logic fin);
        logic [7:0] b;
        i_host.pulse(0, 1'b0);
        i_host.put(a);
        #5 cmp_rd("ack", 8'h01, {7'h0, ack});
        ptr = a;
        for (int k = 0; k < n; k++) begin
            b = xs();
            if (ptr == 8'h08) b = 8'h2E + b % 8'h6A;
            if (ptr == 8'h09) b[5] = 1'b0;
            if (ptr == 8'h0B) b = (b & 8'h10) | 8'h08;
            i_host.put(b);
            #5 cmp_rd("ack", 8'h01, {7'h0, ack});
            if (ptr >= 8'h06 && ptr <= 8'h0B) m[ptr - 8'h06] = b;
            ptr = ptr + 8'h01;
        end
        i_host.idle();
        if (fin) i_host.pulse(1, 1'b0);
    endtask
    task automatic rd_stat();
        wr(8'h0C, 0, 1'b0);
        i_host.pulse(0, 1'b1);
        i_host.req();
        cmp_rd("valid", 8'h01, {7'h0, rv});
        cmp_rd("status", {por, succ & m[1][2], idle, lock, 4'h0}, rdat & 8'hF0);
        i_host.req();
        cmp_rd("next valid", 8'h01, {7'h0, rv});
        cmp_rd("next", 8'h00, rdat);
        i_host.pulse(1, 1'b0);
        por = 1'b0;
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        #(25ns * 20000);
        failures++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        settle();
        cmp_ctl("reset", exp_ctl(), ctl);
        wr(8'h05, 8, 1'b1);
        settle();
        cmp_ctl("burst", exp_ctl(), ctl);
        for (int i = 0; i < 24; i++) begin
            rd_stat();
            wr(xs() % 8'h06 + 8'h06, 1 + xs() % 6, 1'b1);
            settle();
            cmp_ctl("ctl", exp_ctl(), ctl);
        end
        i_host.put(8'h55);
        #5 cmp_rd("idle ack", 8'h00, {7'h0, ack});
        i_host.idle();
        do_reset();
        settle();
        cmp_ctl("reset2", exp_ctl(), ctl);
        tally_and_finish();
    end
endmodule
